// ### hw/bus_cmd_pkg.sv
// Types for the bus command responder.
// Assumes bus_cmd_regs.svh is available for constants.
package bus_cmd_pkg;
    // One-cycle bus events decoded by the interface front end
    typedef struct packed {
        logic dcl;   // Device clear
        logic sdc;   // Selective clear, qualified by the listen flag in the responder
        logic gtl;   // Go to local
        logic unl;   // Unlisten
        logic unt;   // Untalk
        logic spe;   // Serial poll enable
        logic spd;   // Serial poll disable
        logic get;   // Group execute trigger
        logic mta;   // My talk address
        logic mla;   // My listen address
        logic llo;   // Local lockout
    } bus_event_type;
    // Machine state word: parameters per command letter nibble
    typedef struct packed {
        logic [3:0] trig;   // Trigger mode
        logic [3:0] disp;   // Display mode
        logic [3:0] prog;   // Program mode
        logic [3:0] func;   // Function
        logic [15:0] spare; // Other letters
    } mach_state_type;
    // Parser states
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_LETTER,
        PS_BAD
    } parse_state_type;
endpackage

// ### hw/bus_cmd_regs.svh
// Constants for the bus command responder: trigger mode codes, sizes, resets.
// Assumes it is included by its bare name wherever the constants are needed.
`ifndef BUS_CMD_REGS_SVH
`define BUS_CMD_REGS_SVH
// Program memory depth in steps
`define PROG_STEPS          100
// Trigger mode codes held in the machine state
`define TRIG_START_ON_GET   4'h2
`define TRIG_STOP_ON_GET    4'h3
// Execute character
`define EXEC_CHAR           8'h58
// Space is skipped in command strings
`define SPACE_CHAR          8'h20
// Reset value of the machine state word
`define STATE_RESET         32'h0000_0000
// First memory location
`define PTR_FIRST           7'h01
`endif

// ### hw/gpib_bus_command_responder.sv
// Bus command responder: interface clear, remote, addressing, serial poll,
// triggers, clears and device-dependent command buffering.
// Assumes a front end delivers decoded bus events as one-cycle pulses on
// sys_clk and received data bytes with a strobe; bus lines are raw pins.
`timescale 1ns/100ps
`include "bus_cmd_regs.svh"
module gpib_bus_command_responder #(
    parameter int STEPS = `PROG_STEPS  // Program memory depth
) (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       ifc_n_pin,      // Interface clear pin
    input  wire logic                       ren_n_pin,      // Remote enable pin
    input  wire bus_cmd_pkg::bus_event_type bus_evt,        // Decoded command pulses
    input  wire logic                       data_stb,       // Data byte received
    input  wire logic [7:0]                 data_byte,      // Received byte
    input  wire logic                       poll_done,      // Status byte handshake done
    input  wire logic                       srq_enable,     // Service request on command or option error
    input  wire logic [7:0]                 status_in,      // Status byte from the core
    output logic                            remote_q,       // Remote flag and lamp
    output logic                            lockout_q,      // Front panel locked
    output logic                            talk_q,         // Talker addressed, lamp
    output logic                            listen_q,       // Listener addressed, lamp
    output logic                            poll_mode_q,    // Serial poll mode
    output logic                            poll_active_q,  // Presenting status byte
    output logic [7:0]                      talk_byte_q,    // Byte presented to bus
    output logic                            prog_run_q,     // Program running
    output logic [6:0]                      mem_ptr_q,      // Memory pointer
    output logic [6:0]                      disp_ptr_q,     // Display pointer
    output logic                            mem_clear_q,    // Memory erase pulse
    output bus_cmd_pkg::mach_state_type     mach_q,         // Machine state register
    output logic                            err_cmd_q,      // invalid_command_error
    output logic                            err_opt_q,      // invalid_option_error
    output logic                            err_noremote_q, // Command while local
    output logic                            srq_q           // Service request
);
    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // Pointers are seven bits wide, so deeper memories cannot be addressed
    if (STEPS < 1 || STEPS > 127) begin : g_bad_steps
        $error("STEPS must be 1 to 127");
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] ifc_sync_q;  // Two stages, first read only by second
    logic [1:0] ren_sync_q;
    logic       ren_prev_q;  // Previous synchronised remote level
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ifc_sync_q <= 2'h3;
            ren_sync_q <= 2'h3;
            ren_prev_q <= 1'h1;
        end else begin
            ifc_sync_q <= {ifc_sync_q[0], ifc_n_pin};
            ren_sync_q <= {ren_sync_q[0], ren_n_pin};
            ren_prev_q <= ren_sync_q[1];
        end
    end
    logic ifc_act;   // Interface clear held
    logic ren_act;   // Remote enable held
    logic ren_fall;  // Remote enable just asserted
    assign ifc_act  = ~ifc_sync_q[1];
    assign ren_act  = ~ren_sync_q[1];
    assign ren_fall = ren_prev_q & ~ren_sync_q[1];

    // Letter decode shared by the parser; returns field index or 7 if unknown
    function automatic logic [2:0] letter_slot(input logic [7:0] c);
        case (c)
            8'h54:   letter_slot = 3'h0;  // Trigger
            8'h44:   letter_slot = 3'h1;  // Display
            8'h50:   letter_slot = 3'h2;  // Program
            8'h46:   letter_slot = 3'h3;  // Function
            8'h42, 8'h4C, 8'h49, 8'h56, 8'h57, 8'h47, 8'h55: letter_slot = 3'h4;
            default: letter_slot = 3'h7;
        endcase
    endfunction
    // Highest option allowed for each slot
    function automatic logic [3:0] opt_max(input logic [2:0] s);
        case (s)
            3'h0:    opt_max = 4'h5;
            3'h1:    opt_max = 4'h3;
            3'h2:    opt_max = 4'h2;
            3'h3:    opt_max = 4'h1;
            default: opt_max = 4'h9;
        endcase
    endfunction

    // ==========================================================
    // Interface state: remote, addressing, poll
    // ==========================================================
    logic       remote_d, lockout_d, talk_d, listen_d, poll_mode_d, poll_active_d;
    logic [7:0] talk_byte_d;
    always_comb begin
        remote_d      = remote_q;
        lockout_d     = lockout_q;
        talk_d        = talk_q;
        listen_d      = listen_q;
        poll_mode_d   = poll_mode_q;
        poll_active_d = poll_active_q;
        talk_byte_d   = poll_active_q ? status_in : 8'h00;
        // Remote only ever changes these flags, never parameters
        if (ren_fall) begin
            remote_d = 1'b1;
        end
        if (bus_evt.gtl) begin
            remote_d = 1'b0;
        end
        if (bus_evt.llo && ren_act) begin
            lockout_d = 1'b1;
        end
        // Lockout survives go to local; only releasing remote frees it
        if (!ren_act) begin
            remote_d  = 1'b0;
            lockout_d = 1'b0;
        end
        if (bus_evt.mla) begin
            listen_d = 1'b1;
        end
        if (bus_evt.unl) begin
            listen_d = 1'b0;
        end
        // Handshake end first, so a talk address in the same cycle wins
        if (poll_done) begin
            poll_active_d = 1'b0;
        end
        if (bus_evt.mta) begin
            talk_d = 1'b1;
            if (poll_mode_q || bus_evt.spe) begin
                poll_active_d = 1'b1;
            end
        end
        if (bus_evt.unt) begin
            talk_d = 1'b0;
        end
        if (bus_evt.spe) begin
            poll_mode_d = 1'b1;
        end
        if (bus_evt.spd) begin
            poll_mode_d   = 1'b0;
            poll_active_d = 1'b0;
        end
        // Interface clear has last word over talk, listen and poll state
        if (ifc_act) begin
            talk_d        = 1'b0;
            listen_d      = 1'b0;
            poll_mode_d   = 1'b0;
            poll_active_d = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            remote_q      <= 1'b0;
            lockout_q     <= 1'b0;
            talk_q        <= 1'b0;
            listen_q      <= 1'b0;
            poll_mode_q   <= 1'b0;
            poll_active_q <= 1'b0;
            talk_byte_q   <= 8'h00;
        end else begin
            remote_q      <= remote_d;
            lockout_q     <= lockout_d;
            talk_q        <= talk_d;
            listen_q      <= listen_d;
            poll_mode_q   <= poll_mode_d;
            poll_active_q <= poll_active_d;
            talk_byte_q   <= talk_byte_d;
        end
    end

    // ==========================================================
    // Command parser and machine state
    // ==========================================================
    bus_cmd_pkg::parse_state_type ps_q, ps_d;
    bus_cmd_pkg::mach_state_type  tmp_q, tmp_d, mach_d;  // Temporary and applied
    logic [2:0] slot_q, slot_d;     // Letter awaiting its number
    logic       bad_cmd_q, bad_cmd_d, bad_opt_q, bad_opt_d;
    logic       err_cmd_d, err_opt_d, err_nr_d, srq_d;
    logic       run_d, clr_d;
    logic [6:0] mptr_d, dptr_d;
    logic [2:0] s;
    logic       dig, clear_any;
    always_comb begin
        ps_d      = ps_q;
        tmp_d     = tmp_q;
        mach_d    = mach_q;
        slot_d    = slot_q;
        bad_cmd_d = bad_cmd_q;
        bad_opt_d = bad_opt_q;
        err_cmd_d = err_cmd_q;
        err_opt_d = err_opt_q;
        err_nr_d  = err_noremote_q;
        srq_d     = srq_q;
        run_d     = prog_run_q;
        mptr_d    = mem_ptr_q;
        dptr_d    = disp_ptr_q;
        clr_d     = 1'b0;
        s         = letter_slot(data_byte);
        dig       = (data_byte >= 8'h30) && (data_byte <= 8'h39);
        clear_any = bus_evt.dcl || (bus_evt.sdc && listen_q);
        // Status read clears the sticky error flags; a new error still wins
        if (poll_done) begin
            err_cmd_d = 1'b0;
            err_opt_d = 1'b0;
            err_nr_d  = 1'b0;
            srq_d     = 1'b0;
        end
        if (data_stb && listen_q && !remote_q) begin
            err_nr_d = 1'b1;
        end else if (data_stb && listen_q && data_byte != `SPACE_CHAR) begin
            if (data_byte == `EXEC_CHAR) begin
                if (bad_cmd_q || bad_opt_q) begin
                    // Sticky: a string with one fault keeps the other's flag
                    err_cmd_d = err_cmd_d | bad_cmd_q;
                    err_opt_d = err_opt_d | bad_opt_q;
                    srq_d     = srq_d | srq_enable;
                    // Discarded string leaves no trace for the next one
                    tmp_d     = mach_q;
                end else begin
                    mach_d = tmp_q;
                end
                ps_d      = bus_cmd_pkg::PS_IDLE;
                bad_cmd_d = 1'b0;
                bad_opt_d = 1'b0;
            end else if (dig && ps_q == bus_cmd_pkg::PS_LETTER) begin
                if (data_byte[3:0] > opt_max(slot_q)) begin
                    bad_opt_d = 1'b1;
                end else if (slot_q < 3'h4) begin
                    tmp_d[31 - 4 * slot_q -: 4] = data_byte[3:0];
                end
                ps_d = bus_cmd_pkg::PS_IDLE;
            end else if (s == 3'h7) begin
                bad_cmd_d = 1'b1;
                ps_d      = bus_cmd_pkg::PS_BAD;
            end else begin
                // Letter taken with parameter zero until a digit replaces it
                if (s < 3'h4) begin
                    tmp_d[31 - 4 * s -: 4] = 4'h0;
                end
                slot_d = s;
                ps_d   = bus_cmd_pkg::PS_LETTER;
            end
        end
        // Trigger only moves the run flag
        if (bus_evt.get && listen_q) begin
            if (mach_q.trig == `TRIG_START_ON_GET) begin
                run_d = 1'b1;
            end else if (mach_q.trig == `TRIG_STOP_ON_GET) begin
                run_d = 1'b0;
            end
        end
        if (clear_any) begin
            mach_d    = `STATE_RESET;
            tmp_d     = `STATE_RESET;
            ps_d      = bus_cmd_pkg::PS_IDLE;
            bad_cmd_d = 1'b0;
            bad_opt_d = 1'b0;
            run_d     = 1'b0;
            clr_d     = 1'b1;
            mptr_d    = `PTR_FIRST;
            dptr_d    = `PTR_FIRST;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ps_q           <= bus_cmd_pkg::PS_IDLE;
            tmp_q          <= `STATE_RESET;
            mach_q         <= `STATE_RESET;
            slot_q         <= 3'h0;
            bad_cmd_q      <= 1'b0;
            bad_opt_q      <= 1'b0;
            err_cmd_q      <= 1'b0;
            err_opt_q      <= 1'b0;
            err_noremote_q <= 1'b0;
            srq_q          <= 1'b0;
            prog_run_q     <= 1'b0;
            mem_ptr_q      <= `PTR_FIRST;
            disp_ptr_q     <= `PTR_FIRST;
            mem_clear_q    <= 1'b0;
        end else begin
            ps_q           <= ps_d;
            tmp_q          <= tmp_d;
            mach_q         <= mach_d;
            slot_q         <= slot_d;
            bad_cmd_q      <= bad_cmd_d;
            bad_opt_q      <= bad_opt_d;
            err_cmd_q      <= err_cmd_d;
            err_opt_q      <= err_opt_d;
            err_noremote_q <= err_nr_d;
            srq_q          <= srq_d;
            prog_run_q     <= run_d;
            mem_ptr_q      <= mptr_d;
            disp_ptr_q     <= dptr_d;
            mem_clear_q    <= clr_d;
        end
    end
endmodule

// ### tb/bus_cmd_checker_assertions.sv
// Concurrent checks on the responder's ports.
// Assumes it is bound onto gpib_bus_command_responder; one clock domain.
`timescale 1ns/100ps
`include "bus_cmd_regs.svh"
module bus_cmd_checker (
    input wire logic                        sys_clk,
    input wire logic                        sys_rst,
    input wire logic                        ifc_n_pin,
    input wire logic                        ren_n_pin,
    input wire bus_cmd_pkg::bus_event_type  bus_evt,
    input wire logic                        data_stb,
    input wire logic                        poll_done,
    input wire logic                        remote_q,
    input wire logic                        lockout_q,
    input wire logic                        talk_q,
    input wire logic                        listen_q,
    input wire logic                        poll_mode_q,
    input wire logic                        poll_active_q,
    input wire logic                        prog_run_q,
    input wire logic [6:0]                  mem_ptr_q,
    input wire logic                        mem_clear_q,
    input wire bus_cmd_pkg::mach_state_type mach_q
);
    // ==========================================================
    // Shared clock and reset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Talk address while polling, with the clear pin high, no handshake end and no untalk
    sequence s_poll_talk;
        bus_evt.mta && poll_mode_q && ifc_n_pin && !poll_done && !bus_evt.unt;
    endsequence
    // Remote enable taken low and held through the synchroniser
    sequence s_ren_taken;
        $fell(ren_n_pin) ##1 (!ren_n_pin && !bus_evt.gtl) [*3];
    endsequence
    // ==========================================================
    // Checks
    a_dev_clear: assert property (bus_evt.dcl |=> mach_q == '0 && mem_clear_q
        && mem_ptr_q == `PTR_FIRST) else $error("device clear left state");
    a_ifc_idle: assert property (!ifc_n_pin [*3] |=> !talk_q && !listen_q
        && !poll_active_q) else $error("interface clear left addressing");
    a_remote_set: assert property (s_ren_taken |=> remote_q)
        else $error("remote flag not set");
    a_ren_free: assert property (ren_n_pin [*4] |=> !remote_q && !lockout_q)
        else $error("panel still locked");
    a_listen_idle: assert property (bus_evt.unl && !bus_evt.mla |=> !listen_q)
        else $error("listen flag kept");
    a_untalk_idle: assert property (bus_evt.unt && !bus_evt.mta |=> !talk_q)
        else $error("talk flag kept");
    a_trig_start: assert property (bus_evt.get && listen_q &&
        mach_q.trig == `TRIG_START_ON_GET |=> prog_run_q) else $error("program not started");
    a_get_still: assert property (bus_evt.get && !data_stb && !bus_evt.dcl
        && !bus_evt.sdc |=> $stable(mach_q)) else $error("trigger changed state");
    a_poll_talk: assert property (s_poll_talk |=> poll_active_q)
        else $error("poll not active");
    a_poll_end: assert property (poll_done && !bus_evt.mta |=> !poll_active_q)
        else $error("poll still active");
endmodule

// ### tb/bus_controller_model.sv
// Behavioural bus controller: command pulses, data bytes, pin levels, polls.
// Assumes every task is entered just after a falling edge of sys_clk.
`timescale 1ns/100ps
module bus_controller_model (
    input  wire logic                  sys_clk,
    input  wire logic [7:0]            talk_byte_q,
    output logic                       ifc_n_pin,
    output logic                       ren_n_pin,
    output bus_cmd_pkg::bus_event_type bus_evt,
    output logic                       data_stb,
    output logic [7:0]                 data_byte,
    output logic                       poll_done
);
    // ==========================================================
    // Bus idle: lines released high, nothing strobed
    initial begin
        {ifc_n_pin, ren_n_pin} = 2'h3;
        bus_evt = '0;
        {data_stb, poll_done} = 2'h0;
        data_byte = 8'hA5;
    end
    // One-cycle command; n is the bit number in the event struct
    task automatic cmd(input int n);
        bus_evt = bus_cmd_pkg::bus_event_type'(11'h001 << n);
        @(negedge sys_clk);
        bus_evt = '0;
    endtask
    // One byte; the strobe stays up so the next byte follows without a glitch
    task automatic put(input logic [7:0] b);
        {data_stb, data_byte} = {1'h1, b};
        @(negedge sys_clk);
    endtask
    // Characters back to back; afterwards the bus shows the inverse of the last
    task automatic send(input string s);
        foreach (s[i]) put(s[i]);
        {data_stb, data_byte} = {1'h0, ~s[s.len() - 1]};
    endtask
    // Clear and remote enable levels; only this side releases them
    task automatic pins(input logic ifc_v, input logic ren_v);
        {ifc_n_pin, ren_n_pin} = {ifc_v, ren_v};
        @(negedge sys_clk);
    endtask
    // Status byte handshake finished
    task automatic ack();
        poll_done = 1'h1;
        @(negedge sys_clk);
        poll_done = 1'h0;
    endtask
    // Enable poll, address to talk, read one byte, then disable
    task automatic serial_poll(output logic [7:0] st);
        cmd(5);
        // Gap, so the event word is not raised again as it falls
        @(negedge sys_clk);
        cmd(2);
        repeat (3) @(negedge sys_clk);
        st = talk_byte_q;
        ack();
        cmd(4);
    endtask
endmodule

// ### tb/gpib_bus_command_responder_tb_top.sv
// Self-checking bench: random command strings plus bus command corners.
// Assumes the controller model and checker compile first.
`timescale 1ns/100ps
`include "bus_cmd_regs.svh"
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", w, e, g); end end
module gpib_bus_command_responder_tb_top;
    // Bit numbers in the event struct
    localparam int DCL = 10, SDC = 9, GTL = 8, UNL = 7, UNT = 6, GETC = 3, MTA = 2;
    localparam int MLA = 1, LLO = 0;
    logic                        sys_clk = 1'h0;
    logic                        sys_rst = 1'h1;
    logic                        srq_enable = 1'h0;
    logic [7:0]                  status_in = 8'h00;
    logic                        ifc_n_pin, ren_n_pin, data_stb, poll_done, remote_q;
    logic                        lockout_q, talk_q, listen_q, poll_mode_q, poll_active_q;
    logic                        prog_run_q, mem_clear_q, err_cmd_q, err_opt_q, srq_q;
    logic                        err_noremote_q;
    logic [7:0]                  data_byte, talk_byte_q;
    logic [6:0]                  mem_ptr_q, disp_ptr_q;
    bus_cmd_pkg::bus_event_type  bus_evt;
    bus_cmd_pkg::mach_state_type mach_q;
    bus_cmd_pkg::mach_state_type exp_m = '0;   // Expected machine word
    int                          fail_count = 0;
    int                          comparisons = 0;
    int                          seed = 58203;
    // ==========================================================
    // Design and controller, joined by matching names
    gpib_bus_command_responder #(.STEPS(`PROG_STEPS)) uut (.*);
    bus_controller_model ctl (.*);
    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;
    // ==========================================================
    // Helpers; inputs only move on falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic run(input string s);
        ctl.send(s);
        tick(1);
    endtask
    task automatic note(input string n);
        $display("test %s done", n);
    endtask
    // Machine word after one letter and digit; any other letter sets the function field
    function automatic bus_cmd_pkg::mach_state_type apply(
        input bus_cmd_pkg::mach_state_type m, input logic [7:0] l, input logic [3:0] v);
        case (l)
            8'h54: m.trig = v;
            8'h44: m.disp = v;
            8'h50: m.prog = v;
            default: m.func = v;
        endcase
        return m;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] lt [4] = '{8'h54, 8'h44, 8'h50, 8'h46};  // Decoded letters
        logic [3:0] mt [4] = '{4'h5, 4'h3, 4'h2, 4'h1};      // Largest option each
        logic [7:0] st;
        int         i;
        logic [3:0] v;
        tick(10);
        sys_rst = 1'h0;
        tick(1);
        `CHK("reset", {5'h00, 32'h0}, {remote_q, talk_q, listen_q, poll_active_q, lockout_q, mach_q})
        ctl.cmd(MLA);
        run("F0X");
        `CHK("no remote", {1'h1, 32'h0}, {err_noremote_q, mach_q})
        ctl.ack();
        ctl.pins(1'h1, 1'h0);
        tick(4);
        `CHK("remote", {1'h1, 32'h0}, {remote_q, mach_q})
        // Random valid strings; the digit may be zero
        for (int k = 0; k < 40; k++) begin
            i = $unsigned($random(seed)) % 4;
            v = 4'($unsigned($random(seed)) % (mt[i] + 4'h1));
            ctl.put(lt[i]);
            ctl.put(8'h30 + 8'(v));
            run("X");
            exp_m = apply(exp_m, lt[i], v);
            `CHK("mach", exp_m, mach_q)
        end
        run("F1X");
        // Accepted but unused letter, a space, then a bare letter
        run("B9 FX");
        exp_m.func = 4'h0;
        `CHK("bare letter", {2'h0, exp_m}, {err_cmd_q, err_opt_q, mach_q})
        run("D3");
        tick(3);
        `CHK("no execute", exp_m, mach_q)
        run("X");
        exp_m.disp = 4'h3;
        `CHK("execute", exp_m, mach_q)
        srq_enable = 1'h1;
        run("H1X");
        `CHK("bad letter", {2'h3, exp_m}, {err_cmd_q, srq_q, mach_q})
        ctl.ack();
        run("T9X");
        `CHK("bad option", {1'h1, exp_m}, {err_opt_q, mach_q})
        ctl.ack();
        // A lone execute must not apply what the bad string left behind
        run("X");
        `CHK("discarded", exp_m, mach_q)
        note("strings");
        run("T2X");
        ctl.cmd(GETC);
        tick(1);
        exp_m.trig = `TRIG_START_ON_GET;
        `CHK("start", {1'h1, exp_m}, {prog_run_q, mach_q})
        run("T3X");
        ctl.cmd(GETC);
        tick(1);
        exp_m.trig = `TRIG_STOP_ON_GET;
        `CHK("stop", {1'h0, exp_m}, {prog_run_q, mach_q})
        status_in = 8'($random(seed));
        ctl.serial_poll(st);
        tick(1);
        `CHK("status", status_in, st)
        `CHK("poll end", {2'h0, exp_m}, {poll_active_q, poll_mode_q, mach_q})
        ctl.cmd(UNT);
        tick(1);
        `CHK("untalk", 2'h1, {talk_q, listen_q})
        ctl.cmd(UNL);
        tick(1);
        `CHK("unlisten", {2'h0, exp_m}, {talk_q, listen_q, mach_q})
        ctl.cmd(MLA);
        tick(1);
        // The erase pulse stands one cycle: look right after the command
        ctl.cmd(SDC);
        `CHK("sel clear", {8'h81, 32'h0}, {mem_clear_q, disp_ptr_q, mach_q})
        run("P2X");
        ctl.cmd(DCL);
        `CHK("dev clear", {8'h81, 32'h0}, {mem_clear_q, mem_ptr_q, mach_q})
        ctl.cmd(LLO);
        tick(1);
        ctl.cmd(GTL);
        tick(1);
        `CHK("lockout", 2'h1, {remote_q, lockout_q})
        ctl.pins(1'h1, 1'h1);
        tick(4);
        `CHK("ren release", 1'h0, lockout_q)
        ctl.cmd(MTA);
        tick(1);
        ctl.cmd(MLA);
        ctl.pins(1'h0, 1'h1);
        tick(4);
        `CHK("ifc", 2'h0, {talk_q, listen_q})
        ctl.pins(1'h1, 1'h1);
        note("bus");
        complete_run();
    end
endmodule
bind gpib_bus_command_responder bus_cmd_checker chk (.*);
